// File: shared/odc_pkg.sv
// Constants, types and field layout for the eight-channel serial frame receiver.
// Assumes one 200 MHz system clock; the serial pins are asynchronous to it.
//
// Contract
// - A complete frame is at least sixteen falling serial clock edges under low sync.
// - With sync low, each falling serial edge shifts the data pin into sixteen bits.
// - The sixteenth falling edge after sync falls carries the final frame bit.
// - Sync rising after a complete frame executes the received command.
// - Sync rising before the sixteenth edge discards the frame and executes nothing.
// - From the sixteenth falling edge under low sync on, received data is forwarded to chain output.
// - Chained devices share clock and sync and all execute on one sync rise.
// - Chain output is low for fourteen falling edges, high on the fifteenth.
// - The next sixteen falling edges present the first sixteen received bits in order.
// - Eight channels each hold an unsigned twelve-bit data register, zero to 4095.
// - Register-only mode loads without updating outputs; write-through also updates them.
// - Nibble 1000 selects register-only, 1001 write-through; register-only after reset.
// - Top bit zero: bits 14 to 12 select the channel, low twelve the value.
// - 1010 updates masked outputs, 1011 writes A and updates all, 1100 broadcasts.
// - Reset clears all channel registers and holds the outputs at zero.

package odc_pkg;

	// ************************************************************
	// Frame layout
	// ************************************************************
	localparam int FRAME_BITS = 16;
	localparam int CHANNELS = 8;
	localparam int VALUE_BITS = 12;
	localparam int EDGE_BITS = 5;
	localparam logic [4:0] EDGE_MAX = 5'h1f;
	localparam logic [4:0] EDGE_EXECUTE = 5'h10;
	localparam logic [4:0] EDGE_LAST_LOW = 5'h0d;
	localparam logic [4:0] EDGE_MARKER = 5'h0e;
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 12;
	localparam int SEL_MSB = 14;
	localparam int SEL_LSB = 12;
	localparam int CHAIN_TAP = 14;

	// ************************************************************
	// Command nibbles
	// ************************************************************
	localparam logic [3:0] CMD_REG_ONLY = 4'h8;
	localparam logic [3:0] CMD_WRITE_THROUGH = 4'h9;
	localparam logic [3:0] CMD_UPDATE_SELECT = 4'ha;
	localparam logic [3:0] CMD_CHANNEL_A = 4'hb;
	localparam logic [3:0] CMD_BROADCAST = 4'hc;

	typedef enum logic {register_only_mode, write_through_mode} odc_mode_t;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FRAMES = 8'h08;
	localparam logic [7:0] ADDR_ABORTS = 8'h0c;
	localparam logic [7:0] ADDR_LAST_WORD = 8'h10;
	localparam logic [7:0] ADDR_DATA_BASE = 8'h20;
	localparam logic [7:0] ADDR_OUT_BASE = 8'h40;
	localparam logic [7:0] ADDR_BANK_MASK = 8'he0;
	localparam logic CONTROL_RESET = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam int SYNC_STAGES = 2;

endpackage

// File: shared/odc_ser_if.sv
// Carries the sampled serial link state from the frame receiver to the chain output stage.
// Assumes everything here is on the system clock.
`timescale 1ns/100ps

interface odc_ser_if;
	logic fall;
	logic frame;
	logic [4:0] edges;
	logic [15:0] word;

	modport src (output fall, output frame, output edges, output word);
	modport dst (input fall, input frame, input edges, input word);
endinterface

// File: rtl/odc_sync.sv
// Double flip-flop synchronisers for the asynchronous serial pins.
// Assumes pins are plain levels; only the last stage is read downstream.
`timescale 1ns/100ps

module odc_sync #(
	parameter int WIDTH = 3,
	parameter int STAGES = odc_pkg::SYNC_STAGES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH-1:0] pin_idle,
	output logic [WIDTH-1:0] pin_sync
);

	initial begin
		if (STAGES < 2) begin
			$error("odc_sync needs at least two stages");
		end
	end

	// ************************************************************
	// One chain per pin
	// ************************************************************
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			logic [STAGES-1:0] chain;

			// Shift the pin through the stages; idle level under reset so no false edge follows it
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					chain <= {STAGES{pin_idle[b]}};
				end else begin
					chain <= {chain[STAGES-2:0], pin_in[b]};
				end
			end
			assign pin_sync[b] = chain[STAGES-1];
		end
	endgenerate

endmodule // odc_sync

// File: rtl/odc_chain.sv
// Daisy-chain output stage: marker then the delayed serial stream.
// Assumes fall pulses arrive one per falling serial clock edge, with the count before the edge.
`timescale 1ns/100ps

module odc_chain (
	input wire logic aclk,
	input wire logic aresetn,
	odc_ser_if.dst link,
	output logic chain_out
);

	// Low outside frames, low for early edges, marker, then stream
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chain_out <= 1'b0;
		end else if (!link.frame) begin
			chain_out <= 1'b0;
		end else if (link.fall) begin
			if (link.edges <= odc_pkg::EDGE_LAST_LOW) begin
				chain_out <= 1'b0;
			end else if (link.edges == odc_pkg::EDGE_MARKER) begin
				chain_out <= 1'b1;
			end else begin
				chain_out <= link.word[odc_pkg::CHAIN_TAP];
			end
		end
	end

endmodule // odc_chain

// File: rtl/odc_top.sv
// Eight-channel serial frame receiver with daisy-chain output and AXI4-Lite status.
// Assumes sync_n, sclk and din are asynchronous pins; sclk is far slower than aclk.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps

module odc_top #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic din,
	output logic chain_out,
	output logic [95:0] channel_output,
	output logic mode_write_through,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int W = odc_pkg::VALUE_BITS;
	localparam int N = odc_pkg::CHANNELS;

	initial begin
		if (ADDR_WIDTH < 8) begin
			$error("odc_top needs at least eight address bits");
		end
	end

	// ************************************************************
	// Pin sampling and edge detection
	// ************************************************************
	logic [2:0] pin_sync;
	logic sclk_s;
	logic sync_n_s;
	logic din_s;
	logic sclk_prev;
	logic sync_prev;
	logic enable;

	odc_sync #(.WIDTH(3), .STAGES(odc_pkg::SYNC_STAGES)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in({sync_n, sclk, din}),
		.pin_idle(3'h4),
		.pin_sync(pin_sync)
	);

	assign sync_n_s = pin_sync[2];
	assign sclk_s = pin_sync[1];
	assign din_s = pin_sync[0];

	// Previous samples for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_prev <= 1'b0;
			sync_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_s;
			sync_prev <= sync_n_s;
		end
	end

	odc_ser_if link ();

	logic sync_rise;
	assign link.frame = !sync_n_s && !sync_prev && enable;
	assign link.fall = link.frame && sclk_prev && !sclk_s;
	assign sync_rise = sync_n_s && !sync_prev && enable;

	// ************************************************************
	// Shift register and edge counter
	// ************************************************************
	logic [15:0] shift;
	logic [4:0] edges;

	assign link.word = shift;
	assign link.edges = edges;

	// Clear between frames, shift MSB first on each falling edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift <= 16'h0000;
		end else if (sync_n_s && sync_prev) begin
			shift <= 16'h0000;
		end else if (link.fall) begin
			shift <= {shift[14:0], din_s};
		end
	end

	// Count falling edges in a frame, saturating at EDGE_MAX (31)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			edges <= 5'h00;
		end else if (sync_n_s && sync_prev) begin
			edges <= 5'h00;
		end else if (link.fall && edges != odc_pkg::EDGE_MAX) begin
			edges <= edges + 5'h01;
		end
	end

	odc_chain u_chain (
		.aclk(aclk),
		.aresetn(aresetn),
		.link(link),
		.chain_out(chain_out)
	);

	// ************************************************************
	// Command execution
	// ************************************************************
	logic execute;
	logic abort;
	logic [3:0] cmd;
	logic [2:0] sel;
	logic [W-1:0] value;

	assign execute = sync_rise && edges >= odc_pkg::EDGE_EXECUTE;
	assign abort = sync_rise && edges < odc_pkg::EDGE_EXECUTE;
	assign cmd = shift[odc_pkg::CMD_MSB:odc_pkg::CMD_LSB];
	assign sel = shift[odc_pkg::SEL_MSB:odc_pkg::SEL_LSB];
	assign value = shift[W-1:0];

	odc_pkg::odc_mode_t mode;
	odc_pkg::odc_mode_t next_mode;
	logic [W-1:0] data_reg [N];
	logic [W-1:0] next_data [N];
	logic [W-1:0] next_out [N];

	// Decode the frame into new mode, register and output values
	always_comb begin
		next_mode = mode;
		for (int i = 0; i < N; i++) begin
			next_data[i] = data_reg[i];
			next_out[i] = channel_output[i*W +: W];
		end
		if (execute) begin
			case (cmd)
				odc_pkg::CMD_REG_ONLY: begin
					next_mode = odc_pkg::register_only_mode;
				end
				odc_pkg::CMD_WRITE_THROUGH: begin
					next_mode = odc_pkg::write_through_mode;
				end
				odc_pkg::CMD_UPDATE_SELECT: begin
					for (int i = 0; i < N; i++) begin
						if (shift[i]) begin
							next_out[i] = data_reg[i];
						end
					end
				end
				odc_pkg::CMD_CHANNEL_A: begin
					next_data[0] = value;
					next_out[0] = value;
					for (int i = 1; i < N; i++) begin
						next_out[i] = data_reg[i];
					end
				end
				odc_pkg::CMD_BROADCAST: begin
					for (int i = 0; i < N; i++) begin
						next_data[i] = value;
						next_out[i] = value;
					end
				end
				default: begin
					if (!shift[odc_pkg::CMD_MSB]) begin
						next_data[sel] = value;
						if (mode == odc_pkg::write_through_mode) begin
							next_out[sel] = value;
						end
					end
				end
			endcase
		end
	end

	// Channel registers, outputs and mode; all clear at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode <= odc_pkg::register_only_mode;
			mode_write_through <= 1'b0;
			channel_output <= '0;
			for (int i = 0; i < N; i++) begin
				data_reg[i] <= 12'h000;
			end
		end else begin
			mode <= next_mode;
			mode_write_through <= (next_mode == odc_pkg::write_through_mode);
			for (int i = 0; i < N; i++) begin
				data_reg[i] <= next_data[i];
				channel_output[i*W +: W] <= next_out[i];
			end
		end
	end

	// ************************************************************
	// Frame statistics
	// ************************************************************
	logic [15:0] frames;
	logic [15:0] aborts;
	logic [15:0] last_word;

	// Count executed and discarded frames, keep the last executed word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frames <= 16'h0000;
			aborts <= 16'h0000;
			last_word <= 16'h0000;
		end else begin
			if (execute) begin
				frames <= frames + 16'h0001;
				last_word <= shift;
			end
			if (abort) begin
				aborts <= aborts + 16'h0001;
			end
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic aw_held;
	logic w_held;
	logic [7:0] waddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic do_write;

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_held <= 1'b0;
			waddr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_held <= 1'b1;
			waddr <= s_axi_awaddr[7:0];
		end else if (do_write) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	// Write data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_held <= 1'b0;
			wdata <= 32'h00000000;
			wstrb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_held <= 1'b1;
			wdata <= s_axi_wdata;
			wstrb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end else if (!w_held && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Control register and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable <= odc_pkg::CONTROL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= odc_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (waddr == odc_pkg::ADDR_CONTROL) begin
				if (wstrb[0]) begin
					enable <= wdata[0];
				end
				s_axi_bresp <= odc_pkg::RESP_OKAY;
			end else if (waddr <= odc_pkg::ADDR_LAST_WORD && waddr[1:0] == 2'h0) begin
				s_axi_bresp <= odc_pkg::RESP_OKAY;
			end else if ((waddr & odc_pkg::ADDR_BANK_MASK) == odc_pkg::ADDR_DATA_BASE && waddr[1:0] == 2'h0) begin
				s_axi_bresp <= odc_pkg::RESP_OKAY;
			end else if ((waddr & odc_pkg::ADDR_BANK_MASK) == odc_pkg::ADDR_OUT_BASE && waddr[1:0] == 2'h0) begin
				s_axi_bresp <= odc_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= odc_pkg::RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	logic [7:0] raddr;
	logic [2:0] rch;
	assign raddr = s_axi_araddr[7:0];
	assign rch = raddr[4:2];

	// Read address accept and data return
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= odc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= odc_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			if (raddr[1:0] != 2'h0) begin
				s_axi_rresp <= odc_pkg::RESP_DECERR;
			end else if (raddr == odc_pkg::ADDR_CONTROL) begin
				s_axi_rdata <= {31'h00000000, enable};
			end else if (raddr == odc_pkg::ADDR_STATUS) begin
				s_axi_rdata <= {29'h00000000, !sync_n_s, link.frame, mode == odc_pkg::write_through_mode};
			end else if (raddr == odc_pkg::ADDR_FRAMES) begin
				s_axi_rdata <= {16'h0000, frames};
			end else if (raddr == odc_pkg::ADDR_ABORTS) begin
				s_axi_rdata <= {16'h0000, aborts};
			end else if (raddr == odc_pkg::ADDR_LAST_WORD) begin
				s_axi_rdata <= {16'h0000, last_word};
			end else if ((raddr & odc_pkg::ADDR_BANK_MASK) == odc_pkg::ADDR_DATA_BASE) begin
				s_axi_rdata <= {20'h00000, data_reg[rch]};
			end else if ((raddr & odc_pkg::ADDR_BANK_MASK) == odc_pkg::ADDR_OUT_BASE) begin
				s_axi_rdata <= {20'h00000, channel_output[rch*W +: W]};
			end else begin
				s_axi_rresp <= odc_pkg::RESP_DECERR;
			end
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule // odc_top

// File: verif/odc_assertions.sv
// Concurrent checks on the frame receiver top ports.
// Assumes one aclk domain; bound onto every odc_top instance.
`timescale 1ns/100ps

module odc_assertions #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic chain_out,
	input wire logic [95:0] channel_output,
	input wire logic mode_write_through,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Sync low long enough that any earlier execution has landed
	sequence s_deep_frame;
		!sync_n [*8];
	endsequence
	property p_reset_clear;
		$rose(aresetn) |-> channel_output == 96'h0 && !mode_write_through && !chain_out;
	endproperty
	property p_hold_in_frame;
		s_deep_frame |-> $stable(channel_output) && $stable(mode_write_through);
	endproperty
	property p_change_sync_high;
		($changed(channel_output) || $changed(mode_write_through)) |-> sync_n;
	endproperty
	property p_frame_start_low;
		$fell(sync_n) |-> ##6 !chain_out [*8];
	endproperty
	property p_chain_on_low_sclk;
		s_deep_frame ##1 (!sync_n && $changed(chain_out)) |-> !sclk;
	endproperty
	property p_write_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_unaligned_refused;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == odc_pkg::RESP_DECERR;
	endproperty

	a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
	a_hold_in_frame: assert property (p_hold_in_frame) else $error("outputs moved inside a frame");
	a_change_sync_high: assert property (p_change_sync_high) else $error("outputs moved with sync low");
	a_frame_start_low: assert property (p_frame_start_low) else $error("chain out high at frame start");
	a_chain_on_low_sclk: assert property (p_chain_on_low_sclk) else $error("chain out moved off a fall");
	a_write_answer: assert property (p_write_answer) else $error("write response late");
	a_read_answer: assert property (p_read_answer) else $error("read response late");
	a_unaligned_refused: assert property (p_unaligned_refused) else $error("unaligned read not refused");
endmodule // odc_assertions

bind odc_top odc_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_odc_chk (.*);

// File: verif/odc_host.sv
// Serial host model: frames of falling sclk edges, MSB first, echo of chain out.
// Assumes a 125 ns serial period; sclk stands high between frames.
`timescale 1ns/100ps

module odc_host (
	output logic sync_n,
	output logic sclk,
	output logic din,
	input wire logic chain_out
);
	localparam real HALF = 62.5;
	logic [63:0] echo;

	// Idle levels
	initial begin
		sync_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
		echo = 64'h0;
	end

	// One frame of n falling edges; chain out captured at the end of the low phase
	task automatic frame(input logic [63:0] bits, input int n);
		sync_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			din = bits[63-k];
			#HALF sclk = 1'b0;
			#HALF echo = {echo[62:0], chain_out};
			sclk = 1'b1;
		end
		#30 sync_n = 1'b1;
		din = 1'b0;
		#200;
	endtask
endmodule // odc_host

// File: verif/octal_dac_serial_frame_daisy_chain_tb.sv
// Self-checking bench: host frames on the pins, register reads over AXI4-Lite.
// Assumes the host model on the pins and the checker bound to the top.
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("BAD %s exp %h got %h", nm, exp, got); \
	end \
end

module octal_dac_serial_frame_daisy_chain_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic sync_n, sclk, din, chain_out, mode_write_through;
	logic [95:0] channel_output;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic [11:0] dreg [8];
	logic [11:0] oreg [8];
	logic wt;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	int n_exec = 0;

	// ************************************************************
	// Clock, design, host
	// ************************************************************
	always #2.5 aclk = ~aclk;
	odc_top #(.ADDR_WIDTH(8)) dut (.*);
	odc_host host (.sync_n(sync_n), .sclk(sclk), .din(din), .chain_out(chain_out));

	// Bus write: address and data offered together, bready held up
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			aw_ok = aw_ok | s_axi_awready;
			w_ok = w_ok | s_axi_wready;
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Bus read
	task automatic axi_read(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Expected effect of one executed word
	task automatic model(input logic [15:0] w);
		n_exec++;
		if (!w[15]) begin
			dreg[w[14:12]] = w[11:0];
			if (wt) oreg[w[14:12]] = w[11:0];
		end
		else case (w[15:12])
			4'h8: wt = 1'b0;
			4'h9: wt = 1'b1;
			4'ha: for (int i = 0; i < 8; i++) if (w[i]) oreg[i] = dreg[i];
			4'hb: begin
				dreg[0] = w[11:0];
				oreg = dreg;
			end
			4'hc: begin
				dreg = '{default: w[11:0]};
				oreg = dreg;
			end
			default: ;
		endcase
	endtask

	task automatic send(input logic [15:0] w);
		host.frame({w, 48'h0}, 16);
		model(w);
	endtask

	// Mode, outputs and data registers against the model
	task automatic check_all();
		`CHK("mode", wt, mode_write_through)
		for (int i = 0; i < 8; i++) begin
			`CHK("output", oreg[i], channel_output[12*i +: 12])
			axi_read(8'h20 + 8'(4 * i));
			`CHK("data", {20'h0, dreg[i]}, rd)
		end
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end
		else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		dreg = '{default: 12'h000};
		oreg = '{default: 12'h000};
		wt = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		check_all();
		axi_read(odc_pkg::ADDR_CONTROL);
		`CHK("control", odc_pkg::CONTROL_RESET, rd[0])
		axi_read(8'h01);
		`CHK("unaligned", odc_pkg::RESP_DECERR, rsp)
		axi_read(8'hfc);
		`CHK("unmapped", odc_pkg::RESP_DECERR, rsp)
		for (int i = 0; i < 8; i++) send({1'b0, 3'(i), (i == 7) ? 12'hfff : 12'(12'h123 * i)});
		check_all();
		send(16'ha005);
		check_all();
		send(16'h9000);
		send(16'h5abc);
		check_all();
		host.frame({16'h5123, 48'h0}, 14);
		check_all();
		axi_write(odc_pkg::ADDR_CONTROL, 32'h0);
		`CHK("bresp", odc_pkg::RESP_OKAY, rsp)
		host.frame({16'h3321, 48'h0}, 16);
		check_all();
		axi_write(odc_pkg::ADDR_CONTROL, 32'h1);
		send(16'h8000);
		send(16'h2aaa);
		check_all();
		send(16'hb456);
		check_all();
		send(16'hc7ff);
		check_all();
		`CHK("marker", {14'h0, 1'b1, 1'b1}, host.echo[15:0])
		send(16'hd0ff);
		check_all();
		host.frame({16'h1e0f, 16'hc055, 32'h0}, 32);
		model(16'hc055);
		check_all();
		`CHK("chain", {14'h0, 1'b1, 16'h1e0f, 1'b1}, host.echo[31:0])
		axi_read(odc_pkg::ADDR_FRAMES);
		`CHK("frames", 32'(n_exec), rd)
		axi_read(odc_pkg::ADDR_ABORTS);
		`CHK("aborts", 32'h00000001, rd)
		axi_read(odc_pkg::ADDR_LAST_WORD);
		`CHK("last word", 32'h0000c055, rd)
		axi_read(odc_pkg::ADDR_STATUS);
		`CHK("status", {31'h00000000, wt}, rd)
		axi_read(odc_pkg::ADDR_OUT_BASE + 8'h0c);
		`CHK("out bank", {20'h00000, oreg[3]}, rd)
		report_and_stop();
	end
endmodule // octal_dac_serial_frame_daisy_chain_tb
